// [logic/dmast_pkg.sv]
// Package for the DMA status block: register map, field layout, reset values.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package dmast_pkg;

    // ==========================================================================
    // Sizes.
    // ==========================================================================
    localparam int NUM_CHANNELS = 8;    // Channels served by the controller.
    localparam int REG_WIDTH    = 16;   // Width of each status register.
    localparam int ADDR_WIDTH   = 16;   // Width of a DMA RAM start address.
    localparam int WB_AW        = 8;    // Wishbone byte address width.

    // ==========================================================================
    // Register byte offsets.
    // ==========================================================================
    localparam logic [7:0] OFS_COLLISION  = 8'h00;  // Collision flags.
    localparam logic [7:0] OFS_ACTIVITY   = 8'h04;  // Last channel and ping-pong state.
    localparam logic [7:0] OFS_CHAN_MODE  = 8'h08;  // Per-channel enable and mode bits.
    localparam logic [7:0] OFS_START_BASE = 8'h40;  // Start addresses, two words per channel.

    // ==========================================================================
    // Field positions and reset values.
    // ==========================================================================
    localparam int PERIPH_COL_LSB = 8;       // Peripheral collision flags, bits 15:8.
    localparam int RAM_COL_LSB    = 0;       // RAM collision flags, bits 7:0.
    localparam int LAST_CH_LSB    = 8;       // Last active channel, bits 11:8.
    localparam int LAST_CH_WIDTH  = 4;       // Width of the last active channel field.
    localparam int PINGPONG_LSB   = 0;       // Ping-pong selects, bits 7:0.
    localparam int MODE_FIELD_W   = 2;       // Operating mode field width.
    localparam int CHAN_CTL_W     = 3;       // Enable plus mode, per channel in the mode register.
    localparam logic [3:0] LAST_CH_RESET = 4'hF;  // No transfer since reset.
    localparam logic [1:0] MODE_PP_CONT  = 2'h2;  // Continuous with ping-pong.
    localparam logic [1:0] MODE_PP_ONE   = 2'h3;  // One-shot with ping-pong.

endpackage

// [logic/dmast_sticky_flag.sv]
// One sticky collision flag with software clear by writing zero.
// Assumes set and clear strobes are synchronous to mclk.
`timescale 1ns/1ps
module dmast_sticky_flag (
    mclk,
    rst_n,
    set_i,
    clr_i,
    flag
);
    input  wire logic mclk;    // System clock.
    input  wire logic rst_n;   // Synchronous reset, active low.
    input  wire logic set_i;   // Hardware detection strobe.
    input  wire logic clr_i;   // Software clear strobe.
    output logic      flag;    // Flag state.

    logic flag_q;  // Stored flag.
    logic flag_d;  // Next flag value.

    // ==========================================================================
    // Next value: a set in the clear cycle wins so no event is lost.
    // ==========================================================================
    always_comb begin
        flag_d = flag_q;
        if (set_i) begin
            flag_d = 1'b1;
        end else if (clr_i) begin
            flag_d = 1'b0;
        end
    end

    // Register stage; flags come up clear.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule

// [logic/dmast_pingpong.sv]
// Ping-pong buffer select for one channel.
// Assumes block-done strobes come from the transfer engine, one cycle each.
`timescale 1ns/1ps
module dmast_pingpong
    import dmast_pkg::*;
(
    mclk,
    rst_n,
    chan_en,
    chan_mode,
    block_done,
    select_b
);
    input  wire logic       mclk;        // System clock.
    input  wire logic       rst_n;       // Synchronous reset, active low.
    input  wire logic       chan_en;     // Channel enable.
    input  wire logic [1:0] chan_mode;   // Operating mode field.
    input  wire logic       block_done;  // Channel finished a block.
    output logic            select_b;    // One when the secondary buffer is in use.

    logic sel_q;      // Current buffer select.
    logic sel_d;      // Next buffer select.
    logic pp_active;  // Ping-pong mode selected.

    assign pp_active = (chan_mode == MODE_PP_CONT) || (chan_mode == MODE_PP_ONE);

    // ==========================================================================
    // Next value: toggle per block in a ping-pong mode, park on primary while disabled.
    // ==========================================================================
    always_comb begin
        sel_d = sel_q;
        if (!chan_en) begin
            sel_d = 1'b0;
        end else if (pp_active && block_done) begin
            sel_d = ~sel_q;
        end
    end

    // Register stage.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sel_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
        end
    end

    assign select_b = sel_q;
endmodule

// [logic/dmast_status.sv]
// Top of the DMA status block: collision flags, last channel, ping-pong state.
// Assumes a classic Wishbone master and a transfer engine driving the strobes.
//
// Notes on behaviour
// - Peripheral collision flag per channel, bits 15:8.
// - RAM collision flag per channel, bits 7:0.
// - Collision flags reset zero, software only clears.
// - Last channel field bits 11:8, read-only, ones.
// - Field stays all ones until first transfer.
// - Each transfer loads channel number, 0 to 7.
// - Ping-pong bit n: one means secondary address.
// - Activity register bits 15:12 read zero.
// - Ping-pong in modes continuous and one-shot.
// - Primary and secondary 16-bit start address per channel.
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module dmast_status
    import dmast_pkg::*;
#(
    parameter int NCH = NUM_CHANNELS  // Number of channels.
) (
    mclk,
    rst_n,
    wb_cyc_i,
    wb_stb_i,
    wb_we_i,
    wb_adr_i,
    wb_sel_i,
    wb_dat_i,
    wb_dat_o,
    wb_ack_o,
    periph_col_i,
    ram_col_i,
    xfer_done_i,
    xfer_chan_i,
    block_done_i,
    chan_en_o,
    chan_mode_o,
    pingpong_select_o,
    start_addr_o
);
    input  wire logic                  mclk;               // System clock, 200 MHz.
    input  wire logic                  rst_n;              // Synchronous reset, active low.
    input  wire logic                  wb_cyc_i;           // Wishbone cycle.
    input  wire logic                  wb_stb_i;           // Wishbone strobe.
    input  wire logic                  wb_we_i;            // Wishbone write enable.
    input  wire logic [WB_AW-1:0]      wb_adr_i;           // Wishbone byte address.
    input  wire logic [3:0]            wb_sel_i;           // Wishbone byte selects.
    input  wire logic [31:0]           wb_dat_i;           // Wishbone write data.
    output logic      [31:0]           wb_dat_o;           // Wishbone read data.
    output logic                       wb_ack_o;           // Wishbone acknowledge.
    input  wire logic [NCH-1:0]        periph_col_i;       // Peripheral collision strobes.
    input  wire logic [NCH-1:0]        ram_col_i;          // RAM collision strobes.
    input  wire logic                  xfer_done_i;        // One data transfer completed.
    input  wire logic [2:0]            xfer_chan_i;        // Channel of that transfer.
    input  wire logic [NCH-1:0]        block_done_i;       // Block completed per channel.
    output logic      [NCH-1:0]        chan_en_o;          // Channel enables.
    output logic      [NCH*2-1:0]      chan_mode_o;        // Mode fields, two bits each.
    output logic      [NCH-1:0]        pingpong_select_o;  // Buffer select per channel.
    output logic      [NCH*ADDR_WIDTH-1:0] start_addr_o;   // Active start address per channel.

    // ==========================================================================
    // Bus decode.
    // ==========================================================================
    logic                  req;          // Request awaiting acknowledge.
    logic                  wr_stb;       // Write taken this cycle.
    logic                  ack_q;        // Acknowledge register.
    logic                  ack_d;        // Next acknowledge.
    logic [31:0]           rdata_q;      // Read data register.
    logic [31:0]           rdata_d;      // Next read data.
    logic [REG_WIDTH-1:0]  col_word;     // Collision register image.
    logic [REG_WIDTH-1:0]  act_word;     // Activity register image.
    logic [NCH-1:0]        pcol_flag;    // Peripheral collision flags.
    logic [NCH-1:0]        rcol_flag;    // RAM collision flags.
    logic [NCH-1:0]        pp_sel;       // Ping-pong selects.
    logic                  wr_col;       // Write to collision register.
    logic                  wr_mode;      // Write to mode register.

    // A request is answered one cycle after it appears, then ack drops.
    assign req    = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_stb = req && wb_we_i;
    assign wr_col = wr_stb && (wb_adr_i == OFS_COLLISION);
    assign wr_mode = wr_stb && (wb_adr_i == OFS_CHAN_MODE);

    // ==========================================================================
    // Last active channel.
    // ==========================================================================
    logic [LAST_CH_WIDTH-1:0] last_ch_q;  // Last channel that moved data.
    logic [LAST_CH_WIDTH-1:0] last_ch_d;  // Next value.

    // Only codes 0 to 7 can be loaded since the channel input is three bits.
    always_comb begin
        last_ch_d = last_ch_q;
        if (xfer_done_i) begin
            last_ch_d = {1'b0, xfer_chan_i};
        end
    end

    // Holds all ones until the first transfer after reset.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_ch_q <= LAST_CH_RESET;
        end else begin
            last_ch_q <= last_ch_d;
        end
    end

    // ==========================================================================
    // Channel control and start addresses.
    // ==========================================================================
    logic [NCH*CHAN_CTL_W-1:0]   ctl_q;    // Enable and mode per channel.
    logic [NCH*CHAN_CTL_W-1:0]   ctl_d;    // Next control.
    logic [2*NCH*ADDR_WIDTH-1:0] sa_q;     // Primary then secondary, per channel.
    logic [2*NCH*ADDR_WIDTH-1:0] sa_d;     // Next start addresses.
    logic [WB_AW-1:0]            sa_off;   // Offset into the start address area.
    logic [4:0]                  sa_idx;   // Word index in that area.
    logic                        sa_hit;   // Address lies in that area.

    assign sa_off = wb_adr_i - OFS_START_BASE;
    assign sa_idx = sa_off[6:2];
    assign sa_hit = (wb_adr_i >= OFS_START_BASE) && (sa_off < 8'(NCH * 8))
                    && (sa_off[1:0] == 2'h0);

    // Writes honour the low byte lanes; a partial write keeps the unselected bytes.
    always_comb begin
        ctl_d = ctl_q;
        sa_d  = sa_q;
        if (wr_mode) begin
            for (int b = 0; b < 3; b++) begin
                if (wb_sel_i[b]) begin
                    ctl_d[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
        end
        if (wr_stb && sa_hit) begin
            for (int b = 0; b < 2; b++) begin
                if (wb_sel_i[b]) begin
                    sa_d[int'(sa_idx)*ADDR_WIDTH + b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    // Control state register.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl_q <= '0;
            sa_q  <= '0;
        end else begin
            ctl_q <= ctl_d;
            sa_q  <= sa_d;
        end
    end

    // ==========================================================================
    // Per-channel flags and ping-pong logic.
    // ==========================================================================
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            dmast_sticky_flag u_pcol (
                .mclk  (mclk),
                .rst_n (rst_n),
                .set_i (periph_col_i[ch]),
                .clr_i (wr_col && wb_sel_i[1] && !wb_dat_i[PERIPH_COL_LSB + ch]),
                .flag  (pcol_flag[ch])
            );
            dmast_sticky_flag u_rcol (
                .mclk  (mclk),
                .rst_n (rst_n),
                .set_i (ram_col_i[ch]),
                .clr_i (wr_col && wb_sel_i[0] && !wb_dat_i[RAM_COL_LSB + ch]),
                .flag  (rcol_flag[ch])
            );
            dmast_pingpong u_pp (
                .mclk       (mclk),
                .rst_n      (rst_n),
                .chan_en    (ctl_q[ch*CHAN_CTL_W + 2]),
                .chan_mode  (ctl_q[ch*CHAN_CTL_W +: 2]),
                .block_done (block_done_i[ch]),
                .select_b   (pp_sel[ch])
            );
            assign chan_en_o[ch]          = ctl_q[ch*CHAN_CTL_W + 2];
            assign chan_mode_o[ch*2 +: 2] = ctl_q[ch*CHAN_CTL_W +: 2];
            // The engine starts each block from the selected buffer.
            assign start_addr_o[ch*ADDR_WIDTH +: ADDR_WIDTH] =
                sa_q[(2*ch + (pp_sel[ch] ? 1 : 0))*ADDR_WIDTH +: ADDR_WIDTH];
        end
    endgenerate

    assign col_word = {pcol_flag, rcol_flag};
    assign act_word = {4'h0, last_ch_q, pp_sel};

    // ==========================================================================
    // Read mux and acknowledge.
    // ==========================================================================
    // Unmapped addresses still get ack with zero data so the bus never hangs.
    always_comb begin
        ack_d   = req;
        rdata_d = rdata_q;
        if (req) begin
            rdata_d = 32'h0000_0000;
            if (wb_adr_i == OFS_COLLISION) begin
                rdata_d[REG_WIDTH-1:0] = col_word;
            end else if (wb_adr_i == OFS_ACTIVITY) begin
                rdata_d[REG_WIDTH-1:0] = act_word;
            end else if (wb_adr_i == OFS_CHAN_MODE) begin
                rdata_d[NCH*CHAN_CTL_W-1:0] = ctl_q;
            end else if (sa_hit) begin
                rdata_d[ADDR_WIDTH-1:0] = sa_q[int'(sa_idx)*ADDR_WIDTH +: ADDR_WIDTH];
            end
        end
    end

    // Bus response register.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = rdata_q;
    assign pingpong_select_o = pp_sel;
endmodule

// [bench/dmast_status_checker.sv]
// Concurrent checks on the ports of the DMA status block.
// Assumes one clock, synchronous active-low reset and classic Wishbone.
`timescale 1ns/1ps
module dmast_status_checker
    import dmast_pkg::*;
#(
    parameter int NCH = NUM_CHANNELS  // Number of channels.
) (
    input wire logic             mclk,
    input wire logic             rst_n,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic [NCH-1:0]   block_done_i,
    input wire logic [NCH-1:0]   chan_en_o,
    input wire logic [NCH*2-1:0] chan_mode_o,
    input wire logic [NCH-1:0]   pingpong_select_o
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ==========================================================================
    // Bus handshake.
    // ==========================================================================
    // A request not yet answered, then a one-cycle answer.
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence
    // A read answer of the activity register.
    sequence s_act_rd;
        wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) == OFS_ACTIVITY);
    endsequence
    AST_ACK_ONE: assert property (s_req |-> s_ans)
        else $error("request not answered with a single ack");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    // The control word is 24 bits wide; every other register fills only bits 15:0.
    AST_RD_UPPER: assert property (wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:24] == 8'h00
        && ($past(wb_adr_i) == OFS_CHAN_MODE || wb_dat_o[23:16] == 8'h00))
        else $error("upper read half not zero");

    // ==========================================================================
    // Activity register contents.
    // ==========================================================================
    // unimplemented bits.
    AST_ACT_UNIMP: assert property (s_act_rd |-> wb_dat_o[15:12] == 4'h0)
        else $error("activity bits 15:12 not zero");
    AST_ACT_LAST: assert property (s_act_rd |-> !wb_dat_o[11] || wb_dat_o[11:8] == 4'hF)
        else $error("reserved last channel code");
    AST_ACT_PP: assert property (s_act_rd |-> wb_dat_o[7:0] == $past(pingpong_select_o))
        else $error("activity low byte differs from selects");

    // ==========================================================================
    // Ping-pong selects, one set of checks per channel.
    // ==========================================================================
    for (genvar n = 0; n < NCH; n++) begin : g_ch
        AST_PP_TOGGLE: assert property (chan_en_o[n] && chan_mode_o[2*n+1] && block_done_i[n]
            |=> pingpong_select_o[n] != $past(pingpong_select_o[n]))
            else $error("select did not toggle");
        AST_PP_HOLD: assert property (chan_en_o[n] && !(chan_mode_o[2*n+1] && block_done_i[n])
            |=> $stable(pingpong_select_o[n]))
            else $error("select changed without a block");
        AST_PP_OFF: assert property (!chan_en_o[n] |=> !pingpong_select_o[n])
            else $error("select not clear on disabled channel");
    end
endmodule

bind dmast_status dmast_status_checker #(.NCH(NCH)) u_checker (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .block_done_i(block_done_i), .chan_en_o(chan_en_o), .chan_mode_o(chan_mode_o),
    .pingpong_select_o(pingpong_select_o));

// [bench/dmast_engine_model.sv]
// Behavioural transfer engine that feeds the status block its event strobes.
// Assumes it is called by the bench just after a rising edge of mclk.
`timescale 1ns/1ps
module dmast_engine_model (
    input wire logic  mclk,
    output logic [7:0] periph_col,
    output logic [7:0] ram_col,
    output logic [7:0] block_done,
    output logic       xfer_done,
    output logic [2:0] xfer_chan
);
    // Quiet strobes at start; the channel number carries no meaning yet.
    initial begin
        periph_col = 8'h00;
        ram_col    = 8'h00;
        block_done = 8'h00;
        xfer_done  = 1'b0;
        xfer_chan  = 3'h5;
    end

    // ==========================================================================
    // One-cycle event pulse after an optional stall.
    // ==========================================================================
    // The trailing edge keeps two calls from driving in one time step.
    task automatic pulse(input logic [7:0] pc, input logic [7:0] rc, input logic [7:0] bd,
                         input logic xd, input logic [2:0] xc, input int stall);
        repeat (stall) @(posedge mclk);
        periph_col <= pc;
        ram_col    <= rc;
        block_done <= bd;
        xfer_done  <= xd;
        xfer_chan  <= xc;
        @(posedge mclk);
        periph_col <= 8'h00;
        ram_col    <= 8'h00;
        block_done <= 8'h00;
        xfer_done  <= 1'b0;
        // The channel is not qualified now, so it shows the inverse value.
        xfer_chan  <= ~xc;
        @(posedge mclk);
    endtask
endmodule

// [bench/dmast_status_tb_top.sv]
// Self-checking bench of the DMA status block with a Wishbone master.
// Assumes the engine model in its own file and the bound checker.
`timescale 1ns/1ps
module dmast_status_tb_top
    import dmast_pkg::*;
;
    localparam int NCH = NUM_CHANNELS;  // Channels under test.
    typedef struct {logic chk; logic [31:0] val;} dmast_note_t;  // Expected answer.

    logic mclk = 1'b0, rst_n = 1'b0;                   // Clock and reset.
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;  // Bus controls.
    logic [7:0] wb_adr_i = 8'h00;                     // Bus address.
    logic [3:0] wb_sel_i = 4'h0;                      // Byte lanes.
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;          // Bus data.
    logic wb_ack_o, xfer_done_i;                      // Answer and transfer pulse.
    logic [2:0] xfer_chan_i;                          // Transfer channel.
    logic [7:0] periph_col_i, ram_col_i, block_done_i, chan_en_o, pingpong_select_o;
    logic [15:0] chan_mode_o;                         // Mode fields.
    logic [127:0] start_addr_o;                       // Selected start addresses.
    dmast_note_t notes[$];                            // Pending expectations.
    int err_total = 0, total_checks = 0;              // Run counters.
    logic [31:0] exp, ctl;                            // Working values.
    logic [7:0] pc, rc, pp;
    logic [2:0] lc;

    always #2.5 mclk = ~mclk;

    dmast_status DUT (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_col_i(periph_col_i),
        .ram_col_i(ram_col_i), .xfer_done_i(xfer_done_i), .xfer_chan_i(xfer_chan_i),
        .block_done_i(block_done_i), .chan_en_o(chan_en_o), .chan_mode_o(chan_mode_o),
        .pingpong_select_o(pingpong_select_o), .start_addr_o(start_addr_o));
    dmast_engine_model eng (.mclk(mclk), .periph_col(periph_col_i), .ram_col(ram_col_i),
        .block_done(block_done_i), .xfer_done(xfer_done_i), .xfer_chan(xfer_chan_i));

    // ==========================================================================
    // Reporting.
    // ==========================================================================
    task automatic chk_word(input logic [31:0] e, input logic [31:0] g, input string what);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================================
    // Bus master: one classic cycle, waiting on ack under a bound.
    // ==========================================================================
    task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, input logic [31:0] e);
        int n;
        notes.push_back('{!we, e});
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
        wb_adr_i <= a; wb_sel_i <= s; wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            $display("MISMATCH t=%0t no ack", $time);
            wrap_up();
        end
        // Released lines show the inverse so stale values cannot pass.
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_adr_i <= ~a; wb_dat_i <= ~d;
        @(posedge mclk);
    endtask

    // Monitor: each answer takes the oldest note; only reads are compared.
    always @(posedge mclk) begin
        if (wb_ack_o === 1'b1) begin
            if (notes.size() == 0) begin
                chk_word(32'h1, 32'h0, "unexpected ack");
            end else if (notes[0].chk) begin
                chk_word(notes[0].val, wb_dat_o, "read data");
            end
            if (notes.size() != 0) void'(notes.pop_front());
        end
    end

    initial begin
        void'($urandom(93088));
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        wb(0, OFS_COLLISION, 4'hF, 32'h0, 32'h0);
        wb(0, OFS_ACTIVITY, 4'hF, 32'h0, 32'h0F00);
        wb(0, 8'h3C, 4'hF, 32'h0, 32'h0);
        $display("test reset done");
        exp = 32'h0;
        for (int i = 0; i < 4; i++) begin
            pc = 8'($urandom);
            rc = 8'($urandom);
            eng.pulse(pc, rc, 8'h00, 1'b0, 3'h0, i);
            exp[15:0] = exp[15:0] | {pc, rc};
            wb(0, OFS_COLLISION, 4'hF, 32'h0, exp);
        end
        wb(1, OFS_COLLISION, 4'hF, 32'hFFFF, 32'h0);
        wb(0, OFS_COLLISION, 4'hF, 32'h0, exp);
        wb(1, OFS_COLLISION, 4'h1, 32'h0, 32'h0);
        exp[7:0] = 8'h00;
        wb(0, OFS_COLLISION, 4'hF, 32'h0, exp);
        fork
            wb(1, OFS_COLLISION, 4'hF, 32'h0, 32'h0);
            eng.pulse(8'h81, 8'h18, 8'h00, 1'b0, 3'h0, 0);
        join
        wb(0, OFS_COLLISION, 4'hF, 32'h0, 32'h8118);
        wb(1, OFS_ACTIVITY, 4'hF, 32'hFFFF, 32'h0);
        wb(0, OFS_ACTIVITY, 4'hF, 32'h0, 32'h0F00);
        $display("test collision flags done");
        for (int i = 0; i < 8; i++) begin
            lc = (i == 0) ? 3'h7 : 3'($urandom);
            eng.pulse(8'h00, 8'h00, 8'h00, 1'b1, lc, i % 2);
            wb(0, OFS_ACTIVITY, 4'hF, 32'h0, {16'h0, 5'h00, lc, 8'h00});
        end
        $display("test last channel done");
        ctl = 32'h0;
        for (int n = 0; n < NCH; n++) ctl[3*n +: 3] = {1'b1, 2'(n % 4)};
        wb(1, OFS_CHAN_MODE, 4'h7, ctl, 32'h0);
        wb(1, 8'h50, 4'h3, 32'h1234, 32'h0);
        wb(1, 8'h54, 4'h3, 32'hABCD, 32'h0);
        pp = 8'h00;
        for (int k = 0; k < 3; k++) begin
            eng.pulse(8'h00, 8'h00, 8'hFF, 1'b0, 3'h0, k);
            pp = pp ^ 8'hCC;
            wb(0, OFS_ACTIVITY, 4'hF, 32'h0, {16'h0, 5'h00, lc, pp});
            chk_word({16'h0, pp[2] ? 16'hABCD : 16'h1234}, {16'h0, start_addr_o[47:32]},
                     "start address");
        end
        wb(1, OFS_CHAN_MODE, 4'h7, 32'h0, 32'h0);
        wb(0, OFS_ACTIVITY, 4'hF, 32'h0, {16'h0, 5'h00, lc, 8'h00});
        $display("test ping-pong done");
        // A reset in mid-run must drop flags set just before and restore all ones.
        eng.pulse(8'h01, 8'h02, 8'h00, 1'b1, 3'h3, 0);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        wb(0, OFS_COLLISION, 4'hF, 32'h0, 32'h0);
        wb(0, OFS_ACTIVITY, 4'hF, 32'h0, 32'h0F00);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
